// file: fpd_regs.svh
`ifndef FPD_REGS_SVH
`define FPD_REGS_SVH
// Functional notes
// R01: A copy request moves the chosen routine into RAM at the destination.
// R02: A copy request counts only with the unlock key and RAM execution.
// R03: Software runs four no-op instructions right after a copy request.
// R04: Hardware clears the copy request once the routine is in RAM.
// R05: The copy request bit always reads back as zero.
// R06: All interrupts stay disabled and masked while the copy runs.
// R07: Program select bit 0 picks the programming routine; clears when done.
// R08: Erase select bit 0 picks the erasing routine; clears when done.
// R09: Select bits 7 to 1 reset to zero and store what is written.
// R10: Software loads the RAM destination before requesting the copy.
// R11: Software sets exactly one routine select before each copy request.

// Register byte offsets
`define FPD_CTRL_OFF     8'h00
`define FPD_PSEL_OFF     8'h04
`define FPD_ESEL_OFF     8'h08
`define FPD_KEY_OFF      8'h0c
`define FPD_DEST_OFF     8'h10
`define FPD_STAT_OFF     8'h14

// Field positions
`define FPD_COPY_BIT     0
`define FPD_PICK_BIT     0
`define FPD_BUSY_BIT     0
`define FPD_ROUT_BIT     1

// Reset values and codes
`define FPD_REG_RST      8'h00
`define FPD_KEY_UNLOCK   8'ha5
`define FPD_RAM_LOW      8'h00
`endif

// file: fpd_pkg.sv
package fpd_pkg;
  // Copy engine states
  typedef enum logic [1:0]
  {
    FPD_IDLE = 2'b00,
    FPD_COPY = 2'b01,
    FPD_DONE = 2'b10
  } fpd_state_e;
endpackage

// file: fpd_ctrl.sv
`include "fpd_regs.svh"

module fpd_ctrl
  import fpd_pkg::*;
#(
  parameter int ROUTINE_WORDS = 16
)
(
  input  logic        pclk,
  input  logic        presetn,
  input  logic        psel,
  input  logic        penable,
  input  logic        pwrite,
  input  logic [7:0]  paddr,
  input  logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic        pready,
  output logic        pslverr,
  input  logic        exec_in_ram,
  output logic        rom_sel,
  output logic [7:0]  rom_addr,
  input  logic [31:0] rom_rdata,
  output logic        ram_we,
  output logic [15:0] ram_addr,
  output logic [31:0] ram_wdata,
  output logic        copy_busy
);

  localparam logic [7:0] LAST_IDX = 8'(ROUTINE_WORDS - 1);
  localparam int         CHK_MAX  = ROUTINE_WORDS + 3;

  fpd_state_e  state;
  fpd_state_e  next_state;
  logic        copy_request;
  logic        next_copy_request;
  logic [7:0]  program_routine_select;
  logic [7:0]  next_program_routine_select;
  logic [7:0]  erase_routine_select;
  logic [7:0]  next_erase_routine_select;
  logic [7:0]  unlock_key_register;
  logic [7:0]  next_unlock_key_register;
  logic [7:0]  ram_destination_register;
  logic [7:0]  next_ram_destination_register;
  logic        next_rom_sel;
  logic [7:0]  idx;
  logic [7:0]  next_idx;
  logic        next_ram_we;
  logic [15:0] next_ram_addr;
  logic [31:0] next_ram_wdata;
  logic [31:0] next_prdata;
  logic        mapped;
  logic        wr;
  logic        copy_go;
  logic [15:0] ram_base;

  // Address decode; every access completes with no wait state
  always_comb
  begin
    case (paddr)
      `FPD_CTRL_OFF,
      `FPD_PSEL_OFF,
      `FPD_ESEL_OFF,
      `FPD_KEY_OFF,
      `FPD_DEST_OFF,
      `FPD_STAT_OFF: mapped = 1'b1;
      default:       mapped = 1'b0;
    endcase
  end

  assign pready   = 1'b1;
  assign pslverr  = psel && penable && !mapped;
  assign wr       = psel && penable && pwrite && mapped;
  assign ram_base = {ram_destination_register, `FPD_RAM_LOW};
  assign rom_addr = idx;
  assign copy_busy = (state != FPD_IDLE);

  // R02 key and RAM gate
  // A request outside the key or RAM execution is dropped silently
  assign copy_go = wr && (paddr == `FPD_CTRL_OFF)
                   && pwdata[`FPD_COPY_BIT]
                   && (unlock_key_register == `FPD_KEY_UNLOCK)
                   && exec_in_ram && (state == FPD_IDLE);

  // Read data is caught in the setup cycle so it comes from flops
  always_comb
  begin
    next_prdata = prdata;
    if (psel && !penable && !pwrite)
    begin
      next_prdata = 32'h0;
      case (paddr)
        // R05 reads as zero
        `FPD_CTRL_OFF: next_prdata = 32'h0;
        `FPD_PSEL_OFF: next_prdata[7:0] = program_routine_select;
        `FPD_ESEL_OFF: next_prdata[7:0] = erase_routine_select;
        `FPD_KEY_OFF:  next_prdata[7:0] = unlock_key_register;
        `FPD_DEST_OFF: next_prdata[7:0] = ram_destination_register;
        `FPD_STAT_OFF:
        begin
          next_prdata[`FPD_BUSY_BIT] = copy_busy;
          next_prdata[`FPD_ROUT_BIT] = rom_sel;
        end
        default:       next_prdata = 32'h0;
      endcase
    end
  end

  // Register writes and the hardware clears at the end of a copy
  always_comb
  begin
    next_unlock_key_register      = unlock_key_register;
    next_ram_destination_register = ram_destination_register;
    next_program_routine_select   = program_routine_select;
    next_erase_routine_select     = erase_routine_select;
    next_copy_request             = copy_request;
    // R07 clear when done
    // R08 clear when done
    if (state == FPD_DONE)
    begin
      next_copy_request = 1'b0;
      next_program_routine_select[`FPD_PICK_BIT] = 1'b0;
      next_erase_routine_select[`FPD_PICK_BIT]   = 1'b0;
    end
    if (copy_go)
      next_copy_request = 1'b1;
    if (wr)
    begin
      case (paddr)
        // R09 full byte stored
        `FPD_PSEL_OFF: next_program_routine_select = pwdata[7:0];
        `FPD_ESEL_OFF: next_erase_routine_select   = pwdata[7:0];
        `FPD_KEY_OFF:  next_unlock_key_register    = pwdata[7:0];
        `FPD_DEST_OFF:
        begin
          // Moving the target mid-copy would split the routine
          if (!copy_busy)
            next_ram_destination_register = pwdata[7:0];
        end
        default: next_copy_request = next_copy_request;
      endcase
    end
  end

  // R01 copy engine
  // One word per cycle; program pick wins if both selects are set
  always_comb
  begin
    next_state     = state;
    next_idx       = idx;
    next_rom_sel   = rom_sel;
    next_ram_we    = 1'b0;
    next_ram_addr  = ram_addr;
    next_ram_wdata = ram_wdata;
    case (state)
      FPD_IDLE:
      begin
        if (copy_go)
        begin
          next_idx     = 8'h00;
          next_rom_sel = !program_routine_select[`FPD_PICK_BIT];
          if (program_routine_select[`FPD_PICK_BIT]
              || erase_routine_select[`FPD_PICK_BIT])
            next_state = FPD_COPY;
          else
            next_state = FPD_DONE;
        end
      end
      FPD_COPY:
      begin
        next_ram_we    = 1'b1;
        next_ram_addr  = ram_base + {8'h00, idx};
        next_ram_wdata = rom_rdata;
        if (idx == LAST_IDX)
          next_state = FPD_DONE;
        else
          next_idx = idx + 8'h01;
      end
      FPD_DONE:
      begin
        // R04 self clear
        next_state = FPD_IDLE;
      end
      default: next_state = FPD_IDLE;
    endcase
  end

  // State registers
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state                    <= FPD_IDLE;
      copy_request             <= 1'b0;
      program_routine_select   <= `FPD_REG_RST;
      erase_routine_select     <= `FPD_REG_RST;
      unlock_key_register      <= `FPD_REG_RST;
      ram_destination_register <= `FPD_REG_RST;
      rom_sel                  <= 1'b0;
      idx                      <= 8'h00;
      ram_we                   <= 1'b0;
      ram_addr                 <= 16'h0000;
      ram_wdata                <= 32'h0;
      prdata                   <= 32'h0;
    end
    else
    begin
      state                    <= next_state;
      copy_request             <= next_copy_request;
      program_routine_select   <= next_program_routine_select;
      erase_routine_select     <= next_erase_routine_select;
      unlock_key_register      <= next_unlock_key_register;
      ram_destination_register <= next_ram_destination_register;
      rom_sel                  <= next_rom_sel;
      idx                      <= next_idx;
      ram_we                   <= next_ram_we;
      ram_addr                 <= next_ram_addr;
      ram_wdata                <= next_ram_wdata;
      prdata                   <= next_prdata;
    end
  end

  // Checks on the copy flow
  default clocking chk_clk @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  // R01 first word at base
  // A request with no routine picked skips the copy, so only COPY counts
  chk_copy_starts_base: assert property ( // R01
    $rose(copy_request) && state == FPD_COPY
    |=> ram_we && (ram_addr == ram_base))
    else $error("copy did not start at destination");

  // R02 key and RAM gate
  chk_request_needs_key: assert property ( // R02
    $rose(copy_request)
    |-> $past(unlock_key_register) == `FPD_KEY_UNLOCK
        && $past(exec_in_ram))
    else $error("copy request taken without key or RAM run");

  // R04 self clear
  chk_request_self_clear: assert property ( // R04
    $rose(copy_request) |-> ##[1:CHK_MAX] !copy_request)
    else $error("copy request not cleared after copy");

  // R05 reads as zero
  chk_ctrl_reads_zero: assert property ( // R05
    psel && !penable && !pwrite && paddr == `FPD_CTRL_OFF
    |=> prdata == 32'h0)
    else $error("copy request read back nonzero");

  // R07 clear when done
  chk_prog_pick_clear: assert property ( // R07
    state == FPD_DONE && !(wr && paddr == `FPD_PSEL_OFF)
    |=> !program_routine_select[`FPD_PICK_BIT])
    else $error("program pick not cleared at end");

  // R08 clear when done
  chk_erase_pick_clear: assert property ( // R08
    state == FPD_DONE && !(wr && paddr == `FPD_ESEL_OFF)
    |=> !erase_routine_select[`FPD_PICK_BIT])
    else $error("erase pick not cleared at end");

  // R09 upper bits stored
  chk_select_storage: assert property ( // R09
    wr && paddr == `FPD_PSEL_OFF
    |=> program_routine_select[7:1] == $past(pwdata[7:1]))
    else $error("program select upper bits not stored");

  // R09 upper bits stored
  chk_erase_storage: assert property ( // R09
    wr && paddr == `FPD_ESEL_OFF
    |=> erase_routine_select[7:1] == $past(pwdata[7:1]))
    else $error("erase select upper bits not stored");

  // R01 word per cycle
  // Each COPY cycle must land exactly one ROM word at base plus index
  chk_word_stream: assert property ( // R01
    state == FPD_COPY
    |=> ram_we && ram_addr == ram_base + {8'h00, $past(idx)}
        && ram_wdata == $past(rom_rdata))
    else $error("copied word out of place");

  // R01 no stray writes
  chk_no_stray_write: assert property ( // R01
    state != FPD_COPY |=> !ram_we)
    else $error("RAM written outside a copy");

  // R01 target held busy
  chk_dest_held_busy: assert property ( // R01
    copy_busy |=> $stable(ram_destination_register))
    else $error("destination moved during copy");

  // R02 refused request
  chk_refused_request: assert property ( // R02
    state == FPD_IDLE && wr && paddr == `FPD_CTRL_OFF
    && (unlock_key_register != `FPD_KEY_UNLOCK || !exec_in_ram)
    |=> !copy_busy)
    else $error("copy started without key or RAM run");

  // Main scenarios
  cov_copy_done: cover property (
    state == FPD_COPY ##1 state == FPD_DONE);
  cov_refused: cover property (
    wr && paddr == `FPD_CTRL_OFF && pwdata[0] && !copy_go);
  cov_erase_copy: cover property (copy_busy && rom_sel && ram_we);
  cov_unmapped: cover property (pslverr);
  cov_empty_request: cover property (
    copy_go && !program_routine_select[`FPD_PICK_BIT]
    && !erase_routine_select[`FPD_PICK_BIT]);

endmodule

// file: test_flash_program_download_ctrl.sv
`include "fpd_regs.svh"

module test_flash_program_download_ctrl;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int NW = 8;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic        exec_in_ram = 1'b0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        rom_sel;
  logic [7:0]  rom_addr;
  logic [31:0] rom_rdata;
  logic        ram_we;
  logic [15:0] ram_addr;
  logic [31:0] ram_wdata;
  logic        copy_busy;
  logic [31:0] rd;
  logic        last_err;
  logic [15:0] exp_base = 16'h0;
  logic        exp_er = 1'b0;
  int          wcnt = 0;
  int          err_total = 0;
  int          checks_done = 0;

  fpd_ctrl #(.ROUTINE_WORDS(NW)) fpd_ctrl_inst (.pclk(pclk),
    .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .exec_in_ram(exec_in_ram), .rom_sel(rom_sel),
    .rom_addr(rom_addr), .rom_rdata(rom_rdata), .ram_we(ram_we),
    .ram_addr(ram_addr), .ram_wdata(ram_wdata), .copy_busy(copy_busy));

  // Clock at 10 MHz
  always #50 pclk = ~pclk;

  // Routine ROM; source marked in the top half so a wrong pick shows
  assign rom_rdata = {rom_sel ? 16'heeee : 16'haaaa, 8'h00, rom_addr};

  task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp)
    begin
      $display("Error %s expected %h seen %h", what, exp, got);
      err_total++;
    end
  endtask

  task test_done;
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  always @(posedge pclk)
  begin
    if (ram_we === 1'b1)
    begin
      chk("ram_addr", {16'h0, exp_base + wcnt[15:0]}, {16'h0, ram_addr});
      chk("ram_wdata", {exp_er ? 16'heeee : 16'haaaa, 8'h00, wcnt[7:0]},
          ram_wdata);
      wcnt++;
    end
  end

  // One APB transfer; held until pready is seen high
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1)
    begin
      err_total++;
      test_done;
    end
    rd = prdata;
    last_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task t_reset;
    apb(1'b0, `FPD_PSEL_OFF, 32'h0);
    chk("psel reset", 32'h0, rd);
    apb(1'b0, `FPD_ESEL_OFF, 32'h0);
    chk("esel reset", 32'h0, rd);
    apb(1'b0, 8'h40, 32'h0);
    chk("unmapped", 32'h1, {31'h0, last_err});
    $display("test reset done");
  endtask

  // Upper select bits are plain storage
  task t_store;
    apb(1'b1, `FPD_PSEL_OFF, 32'hfe);
    apb(1'b1, `FPD_ESEL_OFF, 32'h54);
    apb(1'b0, `FPD_PSEL_OFF, 32'h0);
    chk("psel store", 32'hfe, rd);
    apb(1'b0, `FPD_ESEL_OFF, 32'h0);
    chk("esel store", 32'h54, rd);
    apb(1'b1, `FPD_DEST_OFF, 32'h3c);
    apb(1'b0, `FPD_DEST_OFF, 32'h0);
    chk("dest store", 32'h3c, rd);
    apb(1'b1, `FPD_KEY_OFF, 32'h1a5);
    apb(1'b0, `FPD_KEY_OFF, 32'h0);
    chk("key store", 32'ha5, rd);
    apb(1'b1, `FPD_PSEL_OFF, 32'h0);
    apb(1'b1, `FPD_ESEL_OFF, 32'h0);
    $display("test store done");
  endtask

  // Running outside RAM, then wrong key: no copy may start
  task t_refuse;
    for (int i = 0; i < 2; i++)
    begin
      exec_in_ram <= (i == 1);
      apb(1'b1, `FPD_KEY_OFF, (i == 1) ? 32'h5a : 32'ha5);
      apb(1'b1, `FPD_PSEL_OFF, 32'h1);
      wcnt = 0;
      apb(1'b1, `FPD_CTRL_OFF, 32'h1);
      apb(1'b0, `FPD_STAT_OFF, 32'h0);
      chk("refused busy", 32'h0, {31'h0, rd[0]});
      chk("refused words", 32'h0, wcnt);
    end
    $display("test refuse done");
  endtask

  // Request with neither routine picked: engine passes straight through
  task t_empty;
    apb(1'b1, `FPD_PSEL_OFF, 32'h0);
    apb(1'b1, `FPD_KEY_OFF, 32'ha5);
    exec_in_ram <= 1'b1;
    wcnt = 0;
    apb(1'b1, `FPD_CTRL_OFF, 32'h1);
    @(posedge pclk);
    chk("empty busy", 32'h1, {31'h0, copy_busy});
    @(posedge pclk);
    chk("empty idle", 32'h0, {31'h0, copy_busy});
    chk("empty words", 32'h0, wcnt);
    $display("test empty done");
  endtask

  // Reset in mid-copy: engine stops and the picks return to zero
  task t_abort;
    apb(1'b1, `FPD_PSEL_OFF, 32'h1);
    apb(1'b1, `FPD_KEY_OFF, 32'ha5);
    exec_in_ram <= 1'b1;
    exp_er = 1'b0;
    wcnt = 0;
    apb(1'b1, `FPD_CTRL_OFF, 32'h1);
    repeat (4) @(posedge pclk);
    presetn <= 1'b0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    chk("abort busy", 32'h0, {31'h0, copy_busy});
    chk("abort words", 32'h3, wcnt);
    apb(1'b0, `FPD_PSEL_OFF, 32'h0);
    chk("abort psel", 32'h0, rd);
    $display("test abort done");
  endtask

  task copy(input logic [7:0] dst, input logic er);
    int n;
    apb(1'b1, `FPD_DEST_OFF, {24'h0, dst});
    apb(1'b1, er ? `FPD_ESEL_OFF : `FPD_PSEL_OFF, 32'h1);
    apb(1'b1, er ? `FPD_PSEL_OFF : `FPD_ESEL_OFF, 32'h0);
    apb(1'b1, `FPD_KEY_OFF, 32'ha5);
    exec_in_ram <= 1'b1;
    exp_base = {dst, 8'h00};
    exp_er = er;
    wcnt = 0;
    apb(1'b1, `FPD_CTRL_OFF, 32'h1);
    // four quiet cycles
    // Nothing touches the bus here, so the busy pin is watched instead
    for (int q = 0; q < 4; q++)
    begin
      @(posedge pclk);
      chk("busy pin", 32'h1, {31'h0, copy_busy});
    end
    apb(1'b0, `FPD_CTRL_OFF, 32'h0);
    chk("request read", 32'h0, rd);
    apb(1'b0, `FPD_STAT_OFF, 32'h0);
    chk("busy source", {30'h0, er, 1'b1}, {30'h0, rd[1:0]});
    // no other traffic
    // Only the busy pin is polled until the copy has finished
    n = 0;
    while (copy_busy !== 1'b0 && n < 50)
    begin
      @(posedge pclk);
      n++;
    end
    if (n >= 50)
    begin
      err_total++;
      test_done;
    end
    chk("words", NW, wcnt);
    apb(1'b0, `FPD_PSEL_OFF, 32'h0);
    chk("psel done", 32'h0, rd);
    apb(1'b0, `FPD_ESEL_OFF, 32'h0);
    chk("esel done", 32'h0, rd);
    $display("test copy %0d done", er);
  endtask

  // Reset for four cycles, then the scenarios
  initial
  begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    t_reset;
    t_store;
    t_refuse;
    t_empty;
    copy(8'h12, 1'b0);
    copy(8'hff, 1'b1);
    t_abort;
    test_done;
  end
endmodule
